//--- rtl/cmbx_consts.svh
// Constants for the mailbox transmit wait and cancel controller.
// Assumes a 32-bit AXI4-Lite register port with byte addresses.
`ifndef CMBX_CONSTS_SVH
`define CMBX_CONSTS_SVH

// Register port geometry
`define CMBX_ADDR_W 8
`define CMBX_MB_N 32
`define CMBX_MB_W 5

// Register byte offsets
`define CMBX_OFF_PEND_HI 8'h00
`define CMBX_OFF_PEND_LO 8'h04
`define CMBX_OFF_CANC_HI 8'h08
`define CMBX_OFF_CANC_LO 8'h0c
`define CMBX_OFF_DIR 8'h10
`define CMBX_OFF_DONE 8'h14
`define CMBX_OFF_ABORT 8'h18
`define CMBX_OFF_IRQ_ST 8'h1c
`define CMBX_OFF_IRQ_MASK 8'h20
`define CMBX_OFF_ENGINE 8'h24

// Reset values
`define CMBX_RST_VEC 32'h0000_0000
`define CMBX_RST_MASK 2'h0

// Field positions
`define CMBX_IRQ_DONE_BIT 0
`define CMBX_IRQ_ABORT_BIT 1
`define CMBX_ENG_BUSY_BIT 0
`define CMBX_ENG_REQ_BIT 1
`define CMBX_ENG_MB_LSB 8

// Bus responses
`define CMBX_RESP_OKAY 2'h0
`define CMBX_RESP_SLVERR 2'h2

`endif

//--- rtl/cmbx_pkg.sv
// Types for the mailbox transmit wait and cancel controller.
// Assumes cmbx_consts.svh is on the include path.
`include "cmbx_consts.svh"

package cmbx_pkg;

    // Transmit engine ownership, one-hot
    typedef enum logic [1:0] {
        CMBX_IDLE = 2'b01,
        CMBX_BUSY = 2'b10
    } cmbx_tx_st_t;

    // State of the controller apart from the sticky flag banks
    typedef struct packed {
        logic [`CMBX_MB_N-1:0] pend;
        logic [`CMBX_MB_N-1:0] canc;
        logic [`CMBX_MB_N-1:0] dir;
        logic [1:0] mask;
        cmbx_tx_st_t st;
        logic [`CMBX_MB_W-1:0] act;
        logic req;
        logic [`CMBX_MB_W-1:0] mb;
        logic aw_have;
        logic [`CMBX_ADDR_W-1:0] aw_addr;
        logic w_have;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } cmbx_state_t;

endpackage : cmbx_pkg

//--- rtl/cmbx_flag_bank.sv
// Sticky flag bank: hardware sets, software clears by writing one.
// Assumes set and clear come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none

module cmbx_flag_bank #(
    parameter int W = 32
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic [W-1:0] set_vec,
    input wire logic [W-1:0] clr_vec,
    output logic [W-1:0] flags
);

    typedef struct packed {
        logic [W-1:0] flags;
    } cmbx_fb_t;

    cmbx_fb_t fb_q;
    cmbx_fb_t fb_d;

    // Set wins over a clear in the same cycle
    always_comb begin
        fb_d.flags = (fb_q.flags & ~clr_vec) | set_vec;
    end

    // State register
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            fb_q <= '0;
        end else begin
            fb_q <= fb_d;
        end
    end

    assign flags = fb_q.flags;

endmodule : cmbx_flag_bank

`default_nettype wire

//--- rtl/cmbx_pick_low.sv
// Picks the lowest set bit of a vector.
// Assumes a purely combinational use; no state.
`timescale 1ns/1ps
`default_nettype none

module cmbx_pick_low #(
    parameter int W = 32,
    parameter int IW = 5
) (
    input wire logic [W-1:0] vec,
    output logic found,
    output logic [IW-1:0] index
);

    // Scan downward so the lowest set bit is kept
    always_comb begin
        found = 1'b0;
        index = '0;
        for (int i = W - 1; i >= 0; i--) begin
            if (vec[i]) begin
                found = 1'b1;
                index = IW'(i);
            end
        end
    end

endmodule : cmbx_pick_low

`default_nettype wire

//--- rtl/cmbx_tx_ctrl.sv
// Mailbox transmit wait and cancel controller, AXI4-Lite register slave.
// Assumes a transmit engine on the same clock that takes the offered
// mailbox with tx_start and ends it with tx_ok or tx_fail.
//
// Behaviour
// - A wait bit set in the lower register puts mailboxes 1 to 15 up for arbitration.
// - A wait bit is cleared when its frame is sent or when its abort completes.
// - Of the two frame ends, only a normally sent frame clears the wait bit; a failed try stays queued.
// - Bit 0 of the lower wait and cancel registers reads zero; software writes zero.
// - Writing one to a wait or cancel bit only takes effect for a transmit mailbox.
// - A cancel bit asks to withdraw that mailbox's message, upper 16 to 31, lower 1 to 15.
// - A successful cancel clears the wait and cancel bits and sets the abort flag.
// - A cancel does not stop a frame that has already started.
// - A cancel bit clears on a successful cancel, at the normal end of the frame, or when its wait bit is clear.
// - The upper wait register does the same for mailboxes 16 to 31.
// - A sent frame sets its done flag, which software clears by writing one.
`timescale 1ns/1ps
`default_nettype none
`include "cmbx_consts.svh"

module cmbx_tx_ctrl (
    input wire logic clock,
    input wire logic resetn,
    input wire logic [`CMBX_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`CMBX_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic tx_req,
    output logic [`CMBX_MB_W-1:0] tx_mailbox,
    input wire logic tx_start,
    input wire logic tx_ok,
    input wire logic tx_fail,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    // Aligned word address
    function automatic logic [`CMBX_ADDR_W-1:0] word_addr(
        input logic [`CMBX_ADDR_W-1:0] a
    );
        word_addr = {a[`CMBX_ADDR_W-1:2], 2'b00};
    endfunction : word_addr

    // Mapped register check
    function automatic logic reg_hit(input logic [`CMBX_ADDR_W-1:0] a);
        case (word_addr(a))
            `CMBX_OFF_PEND_HI, `CMBX_OFF_PEND_LO, `CMBX_OFF_CANC_HI,
            `CMBX_OFF_CANC_LO, `CMBX_OFF_DIR, `CMBX_OFF_DONE,
            `CMBX_OFF_ABORT, `CMBX_OFF_IRQ_ST, `CMBX_OFF_IRQ_MASK,
            `CMBX_OFF_ENGINE: reg_hit = 1'b1;
            default: reg_hit = 1'b0;
        endcase
    endfunction : reg_hit

    // Byte enables to bit mask
    function automatic logic [31:0] strb_mask(input logic [3:0] s);
        strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction : strb_mask

    ////////////////////////////////////////////////////////////////////////
    // State and nets

    cmbx_pkg::cmbx_state_t q;
    cmbx_pkg::cmbx_state_t n;
    logic [`CMBX_MB_N-1:0] done_q;
    logic [`CMBX_MB_N-1:0] abort_q;
    logic [1:0] irq_st_q;
    logic [`CMBX_MB_N-1:0] done_set;
    logic [`CMBX_MB_N-1:0] done_clr;
    logic [`CMBX_MB_N-1:0] abort_set;
    logic [`CMBX_MB_N-1:0] abort_clr;
    logic [1:0] irq_set;
    logic [1:0] irq_clr;
    logic [`CMBX_MB_N-1:0] lock;
    logic [`CMBX_MB_N-1:0] hit;
    logic [31:0] wdat;
    logic [31:0] wmask;
    logic do_wr;
    logic pick_found;
    logic [`CMBX_MB_W-1:0] pick_idx;

    ////////////////////////////////////////////////////////////////////////
    // Sticky flags and picker

    // Per-mailbox done flags
    cmbx_flag_bank #(.W(`CMBX_MB_N)) u_done (
        .clock(clock),
        .resetn(resetn),
        .set_vec(done_set),
        .clr_vec(done_clr),
        .flags(done_q)
    );

    // Per-mailbox abort flags
    cmbx_flag_bank #(.W(`CMBX_MB_N)) u_abort (
        .clock(clock),
        .resetn(resetn),
        .set_vec(abort_set),
        .clr_vec(abort_clr),
        .flags(abort_q)
    );

    // Interrupt status: done and abort events
    cmbx_flag_bank #(.W(2)) u_irq (
        .clock(clock),
        .resetn(resetn),
        .set_vec(irq_set),
        .clr_vec(irq_clr),
        .flags(irq_st_q)
    );

    // Lowest waiting mailbox wins arbitration for the offer
    cmbx_pick_low #(.W(`CMBX_MB_N), .IW(`CMBX_MB_W)) u_pick (
        .vec(q.pend),
        .found(pick_found),
        .index(pick_idx)
    );

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        n = q;
        done_set = '0;
        done_clr = '0;
        abort_clr = '0;
        irq_clr = '0;
        lock = '0;
        wmask = strb_mask(q.w_strb);
        wdat = q.w_data & wmask;
        do_wr = q.aw_have && q.w_have && !q.bvalid;

        // Address and data captured in either order
        if (s_axi_awvalid && s_axi_awready) begin
            n.aw_have = 1'b1;
            n.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            n.w_have = 1'b1;
            n.w_data = s_axi_wdata;
            n.w_strb = s_axi_wstrb;
        end

        // Frame in flight or just starting is locked against cancel
        if (q.st == cmbx_pkg::CMBX_BUSY) begin
            lock[q.act] = 1'b1;
        end else if (tx_start && tx_req) begin
            lock[q.mb] = 1'b1;
        end

        // Transmit engine events
        case (q.st)
            cmbx_pkg::CMBX_IDLE: begin
                if (tx_start && tx_req) begin
                    n.st = cmbx_pkg::CMBX_BUSY;
                    n.act = q.mb;
                end
            end
            cmbx_pkg::CMBX_BUSY: begin
                if (tx_ok) begin
                    n.pend[q.act] = 1'b0;
                    n.canc[q.act] = 1'b0;
                    done_set[q.act] = 1'b1;
                    n.st = cmbx_pkg::CMBX_IDLE;
                end else if (tx_fail) begin
                    n.st = cmbx_pkg::CMBX_IDLE;
                end
            end
            default: begin
                n.st = cmbx_pkg::CMBX_IDLE;
            end
        endcase

        // Cancel of waiting, unlocked mailboxes
        hit = q.canc & q.pend & ~lock;
        abort_set = hit;
        n.pend = n.pend & ~hit;
        n.canc = n.canc & ~hit & ~(q.canc & ~q.pend);

        // Register writes; software sets land after hardware clears
        if (do_wr) begin
            n.aw_have = 1'b0;
            n.w_have = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = reg_hit(q.aw_addr) ? `CMBX_RESP_OKAY : `CMBX_RESP_SLVERR;
            case (word_addr(q.aw_addr))
                `CMBX_OFF_PEND_HI: begin
                    n.pend[31:16] = n.pend[31:16] | (wdat[15:0] & q.dir[31:16]);
                end
                `CMBX_OFF_PEND_LO: begin
                    n.pend[15:1] = n.pend[15:1] | (wdat[15:1] & q.dir[15:1]);
                end
                `CMBX_OFF_CANC_HI: begin
                    n.canc[31:16] = n.canc[31:16] | (wdat[15:0] & q.dir[31:16]);
                end
                `CMBX_OFF_CANC_LO: begin
                    n.canc[15:1] = n.canc[15:1] | (wdat[15:1] & q.dir[15:1]);
                end
                `CMBX_OFF_DIR: begin
                    n.dir = (q.dir & ~wmask) | wdat;
                    n.dir[0] = 1'b0;
                end
                `CMBX_OFF_DONE: begin
                    done_clr = wdat;
                end
                `CMBX_OFF_ABORT: begin
                    abort_clr = wdat;
                end
                `CMBX_OFF_IRQ_ST: begin
                    irq_clr = wdat[1:0];
                end
                `CMBX_OFF_IRQ_MASK: begin
                    n.mask = (q.mask & ~wmask[1:0]) | wdat[1:0];
                end
                default: begin
                end
            endcase
        end
        if (q.bvalid && s_axi_bready) begin
            n.bvalid = 1'b0;
        end

        // Register reads, answered at the address edge
        if (s_axi_arvalid && s_axi_arready) begin
            n.rvalid = 1'b1;
            n.rresp = reg_hit(s_axi_araddr) ? `CMBX_RESP_OKAY : `CMBX_RESP_SLVERR;
            case (word_addr(s_axi_araddr))
                `CMBX_OFF_PEND_HI: n.rdata = {16'h0000, q.pend[31:16]};
                `CMBX_OFF_PEND_LO: n.rdata = {16'h0000, q.pend[15:1], 1'b0};
                `CMBX_OFF_CANC_HI: n.rdata = {16'h0000, q.canc[31:16]};
                `CMBX_OFF_CANC_LO: n.rdata = {16'h0000, q.canc[15:1], 1'b0};
                `CMBX_OFF_DIR: n.rdata = q.dir;
                `CMBX_OFF_DONE: n.rdata = done_q;
                `CMBX_OFF_ABORT: n.rdata = abort_q;
                `CMBX_OFF_IRQ_ST: n.rdata = {30'h0000_0000, irq_st_q};
                `CMBX_OFF_IRQ_MASK: n.rdata = {30'h0000_0000, q.mask};
                `CMBX_OFF_ENGINE: begin
                    n.rdata = 32'h0000_0000;
                    n.rdata[`CMBX_ENG_BUSY_BIT] = (q.st == cmbx_pkg::CMBX_BUSY);
                    n.rdata[`CMBX_ENG_REQ_BIT] = tx_req;
                    n.rdata[`CMBX_ENG_MB_LSB +: `CMBX_MB_W] = q.act;
                end
                default: n.rdata = 32'h0000_0000;
            endcase
        end else if (q.rvalid && s_axi_rready) begin
            n.rvalid = 1'b0;
        end

        // Offer for the next cycle from the current wait bits
        n.req = pick_found;
        n.mb = pick_idx;

        // Reserved bit 0 never holds
        n.pend[0] = 1'b0;
        n.canc[0] = 1'b0;

        // Interrupt events
        irq_set = '0;
        irq_set[`CMBX_IRQ_DONE_BIT] = |done_set;
        irq_set[`CMBX_IRQ_ABORT_BIT] = |abort_set;
    end

    ////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            q <= '0;
            q.pend <= `CMBX_RST_VEC;
            q.canc <= `CMBX_RST_VEC;
            q.dir <= `CMBX_RST_VEC;
            q.mask <= `CMBX_RST_MASK;
            q.st <= cmbx_pkg::CMBX_IDLE;
            q.bresp <= `CMBX_RESP_OKAY;
            q.rresp <= `CMBX_RESP_OKAY;
        end else begin
            q <= n;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    // Stale offer is withdrawn once its wait bit has gone
    assign tx_req = q.req && q.pend[q.mb] && (q.st == cmbx_pkg::CMBX_IDLE);
    assign tx_mailbox = q.mb;
    assign s_axi_awready = !q.aw_have;
    assign s_axi_wready = !q.w_have;
    assign s_axi_bvalid = q.bvalid;
    assign s_axi_bresp = q.bresp;
    assign s_axi_arready = !q.rvalid;
    assign s_axi_rvalid = q.rvalid;
    assign s_axi_rdata = q.rdata;
    assign s_axi_rresp = q.rresp;
    assign irq = |(irq_st_q & q.mask);

    ////////////////////////////////////////////////////////////////////////
    // Checks

    logic busy;
    logic [`CMBX_MB_N-1:0] orphan;
    assign busy = (q.st == cmbx_pkg::CMBX_BUSY);
    assign orphan = q.canc & ~q.pend & ~abort_q;

    sequence s_ok_end;
        busy && tx_ok;
    endsequence

    sequence s_fail_end;
        busy && tx_fail && !tx_ok;
    endsequence

    reserved_bits_zero_a: assert property (
        @(posedge clock) disable iff (!resetn)
        !q.pend[0] && !q.canc[0] && (!q.rvalid ||
        !(word_addr(s_axi_araddr) inside {`CMBX_OFF_PEND_LO, `CMBX_OFF_CANC_LO}) ||
        !s_axi_rdata[0]))
        else $error("reserved bit 0 seen as one");

    sent_clears_wait_a: assert property (
        @(posedge clock) disable iff (!resetn)
        s_ok_end |=> !q.pend[$past(q.act)] && !q.canc[$past(q.act)] && !busy)
        else $error("sent frame left wait or cancel bit set");

    sent_sets_done_a: assert property (
        @(posedge clock) disable iff (!resetn)
        s_ok_end |=> done_q[$past(q.act)] ##1 (irq_st_q[0] || $past(irq_clr[0])))
        else $error("sent frame did not set its done flag");

    fail_keeps_wait_a: assert property (
        @(posedge clock) disable iff (!resetn)
        s_fail_end |=> q.pend[$past(q.act)] && !busy && !done_q[$past(q.act)] ||
        $past(done_q[q.act]))
        else $error("failed frame lost its wait bit");

    cancel_aborts_a: assert property (
        @(posedge clock) disable iff (!resetn)
        (|hit) |=> ((q.pend & $past(hit)) == '0) && ((abort_q & $past(hit)) == $past(hit)))
        else $error("cancel did not clear wait or set abort");

    started_not_cancel_a: assert property (
        @(posedge clock) disable iff (!resetn)
        busy && q.canc[q.act] && !tx_ok |=> q.pend[$past(q.act)] [*1] ##0
        !abort_q[$past(q.act)] || $past(abort_q[q.act]))
        else $error("frame in flight was cancelled");

    transmit_only_a: assert property (
        @(posedge clock) disable iff (!resetn)
        ((q.pend & ~$past(q.pend) & ~q.dir) == '0) &&
        ((q.canc & ~$past(q.canc) & ~q.dir) == '0))
        else $error("wait or cancel set on non-transmit mailbox");

    idle_cancel_quiet_a: assert property (
        @(posedge clock) disable iff (!resetn)
        (|orphan) |=> ((abort_q & $past(orphan)) == '0) &&
        ((q.canc & $past(orphan)) == '0))
        else $error("cancel of idle mailbox set abort flag");

    wait_offered_a: assert property (
        @(posedge clock) disable iff (!resetn)
        (|q.pend) && !busy && !tx_start [*2] |-> tx_req)
        else $error("waiting mailbox not offered");

endmodule : cmbx_tx_ctrl

`default_nettype wire

//--- tb/cmbx_eng_model.sv
// Transmit engine model: takes offered mailboxes, then sends or fails them.
// Assumes the controller's tx_req is a level and it samples tx_start once.
`timescale 1ns/1ps
`default_nettype none
`include "cmbx_consts.svh"

module cmbx_eng_model #(
    parameter int FRAME_LEN = 60
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic tx_req,
    input wire logic [`CMBX_MB_W-1:0] tx_mailbox,
    input wire logic go,
    input wire logic fail_once,
    output logic tx_start,
    output logic tx_ok,
    output logic tx_fail,
    output logic [`CMBX_MB_W-1:0] last_mb,
    output logic [7:0] n_start,
    output logic [7:0] n_end
);
    logic busy_q;
    int cnt_q;

    ////////////////////////////////////////////////////////////////////////////
    // Take a standing offer, end it after a fixed frame time
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            busy_q <= 1'b0;
            cnt_q <= 0;
            tx_start <= 1'b0;
            tx_ok <= 1'b0;
            tx_fail <= 1'b0;
            last_mb <= '0;
            n_start <= 8'h00;
            n_end <= 8'h00;
        end else begin
            tx_start <= 1'b0;
            tx_ok <= 1'b0;
            tx_fail <= 1'b0;
            if (busy_q) begin
                cnt_q <= cnt_q - 1;
                if (cnt_q == 0) begin
                    busy_q <= 1'b0;
                    tx_ok <= !fail_once;  // Exactly one of ok or fail
                    tx_fail <= fail_once;
                    n_end <= n_end + 8'h01;
                end
            end else if (go && tx_req && !tx_ok && !tx_fail) begin
                tx_start <= 1'b1;  // One cycle gap after an end
                busy_q <= 1'b1;
                cnt_q <= FRAME_LEN;
                last_mb <= tx_mailbox;
                n_start <= n_start + 8'h01;
            end
        end
    end
endmodule : cmbx_eng_model
`default_nettype wire

//--- tb/tb_can_mailbox_tx_request_cancel.sv
// Testbench for the mailbox transmit wait and cancel controller.
// Assumes the design files and the engine model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "cmbx_consts.svh"

module tb_can_mailbox_tx_request_cancel;
    typedef struct packed {
        logic [7:0] a;
        logic [31:0] d;
        logic [31:0] e;
        logic [1:0] r;
    } cmbx_row_t;

    logic clock, resetn, go, fail_once, tx_req, tx_start, tx_ok, tx_fail, irq;
    logic [7:0] s_axi_awaddr, s_axi_araddr, n_start, n_end;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd_data;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, wr_resp, rd_resp;
    logic [4:0] tx_mailbox, last_mb;
    int n_fail, num_checks;
    cmbx_row_t rows [6] = '{
        '{8'h04, 32'h0000_fffe, 32'h0, `CMBX_RESP_OKAY},
        '{8'h0c, 32'h0000_fffe, 32'h0, `CMBX_RESP_OKAY},
        '{8'h00, 32'h0000_ffff, 32'h0, `CMBX_RESP_OKAY},
        '{8'h10, 32'h0002_000f, 32'h0002_000e, `CMBX_RESP_OKAY},
        '{8'h20, 32'hffff_ffff, 32'h3, `CMBX_RESP_OKAY},
        '{8'h28, 32'hffff_ffff, 32'h0, `CMBX_RESP_SLVERR}};

    cmbx_tx_ctrl cmbx_tx_ctrl_i (.clock, .resetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .tx_req, .tx_mailbox, .tx_start, .tx_ok, .tx_fail, .irq);
    cmbx_eng_model cmbx_eng_model_i (.clock, .resetn, .tx_req, .tx_mailbox, .go,
        .fail_once, .tx_start, .tx_ok, .tx_fail, .last_mb, .n_start, .n_end);

    ////////////////////////////////////////////////////////////////////////////
    // Clock and watchdog
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    initial begin
        #500us;
        n_fail++;
        give_verdict();
    end

    ////////////////////////////////////////////////////////////////////////////
    // Tasks
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : give_verdict

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int t;
        @(posedge clock);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        t = 0;
        do begin
            @(posedge clock);
            t++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid && t < 50);
        wr_resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        if (t >= 50) n_fail++;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        int t;
        @(posedge clock);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        t = 0;
        do begin
            @(posedge clock);
            t++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid && t < 50);
        rd_data = s_axi_rdata;
        rd_resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        if (t >= 50) n_fail++;
    endtask : rd

    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        rd(a);
        chk(nm, rd_data, e);
    endtask : rchk

    // Bounded wait on the engine's start or end count
    task automatic wait_cnt(input bit starts, input int target);
        int t;
        t = 0;
        while ((starts ? n_start : n_end) != target && t < 500) begin
            @(posedge clock);
            t++;
        end
        if (t >= 500) n_fail++;
    endtask : wait_cnt

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        n_fail = 0;
        num_checks = 0;
        {resetn, go, fail_once, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hf;
        repeat (16) @(posedge clock);
        resetn <= 1'b1;
        for (int i = 0; i < 10; i++) rchk("reset value", 8'(4 * i), 32'h0);
        chk("irq after reset", {31'h0, irq}, 32'h0);
        $display("reset test done");
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            chk("write response", {30'h0, wr_resp}, {30'h0, rows[i].r});
            rd(rows[i].a);
            chk("read data", rd_data, rows[i].e);
            chk("read response", {30'h0, rd_resp}, {30'h0, rows[i].r});
            $display("row %0d done", i);
        end
        // Lower and upper mailbox sent normally
        go <= 1'b1;
        wr(`CMBX_OFF_PEND_LO, 32'h8);
        wait_cnt(1'b0, 1);
        chk("offered mailbox", {27'h0, last_mb}, 32'd3);
        rchk("wait low", `CMBX_OFF_PEND_LO, 32'h0);
        rchk("done flags", `CMBX_OFF_DONE, 32'h8);
        chk("irq on done", {31'h0, irq}, 32'h1);
        wr(`CMBX_OFF_DONE, 32'h8);
        wr(`CMBX_OFF_IRQ_ST, 32'h1);
        rchk("done cleared", `CMBX_OFF_DONE, 32'h0);
        chk("irq cleared", {31'h0, irq}, 32'h0);
        wr(`CMBX_OFF_PEND_HI, 32'h2);
        wait_cnt(1'b0, 2);
        chk("upper mailbox", {27'h0, last_mb}, 32'd17);
        rchk("upper done", `CMBX_OFF_DONE, 32'h0002_0000);
        wr(`CMBX_OFF_DONE, 32'h0002_0000);
        $display("send test done");
        // Failed attempt stays queued and is retried
        fail_once <= 1'b1;
        wr(`CMBX_OFF_PEND_LO, 32'h4);
        wait_cnt(1'b0, 3);
        fail_once <= 1'b0;
        wait_cnt(1'b0, 4);
        chk("starts after retry", {24'h0, n_start}, 32'd4);
        rchk("retried done", `CMBX_OFF_DONE, 32'h4);
        wr(`CMBX_OFF_DONE, 32'h4);
        wr(`CMBX_OFF_IRQ_ST, 32'h1);
        $display("retry test done");
        // Cancel of waiting mailboxes, lower and upper
        go <= 1'b0;
        wr(`CMBX_OFF_PEND_LO, 32'h8);
        wr(`CMBX_OFF_CANC_LO, 32'h8);
        rchk("wait after cancel", `CMBX_OFF_PEND_LO, 32'h0);
        rchk("cancel cleared", `CMBX_OFF_CANC_LO, 32'h0);
        chk("irq on abort", {31'h0, irq}, 32'h1);
        wr(`CMBX_OFF_PEND_HI, 32'h2);
        wr(`CMBX_OFF_CANC_HI, 32'h2);
        rchk("abort flags", `CMBX_OFF_ABORT, 32'h0002_0008);
        chk("no frame sent", {24'h0, n_start}, 32'd4);
        wr(`CMBX_OFF_ABORT, 32'h0002_0008);
        wr(`CMBX_OFF_IRQ_ST, 32'h2);
        $display("cancel test done");
        // Cancel after the frame started has no effect
        go <= 1'b1;
        wr(`CMBX_OFF_PEND_LO, 32'h8);
        wait_cnt(1'b1, 5);
        wr(`CMBX_OFF_CANC_LO, 32'h8);
        rchk("engine status", `CMBX_OFF_ENGINE, 32'h0000_0301);
        rchk("cancel in flight", `CMBX_OFF_CANC_LO, 32'h8);
        wait_cnt(1'b0, 5);
        rchk("cancel at end", `CMBX_OFF_CANC_LO, 32'h0);
        rchk("no abort", `CMBX_OFF_ABORT, 32'h0);
        rchk("sent anyway", `CMBX_OFF_DONE, 32'h8);
        $display("late cancel test done");
        // Cancel on an idle mailbox changes nothing
        go <= 1'b0;
        wr(`CMBX_OFF_CANC_LO, 32'h2);
        rchk("idle cancel", `CMBX_OFF_CANC_LO, 32'h0);
        rchk("idle no abort", `CMBX_OFF_ABORT, 32'h0);
        rchk("idle wait", `CMBX_OFF_PEND_LO, 32'h0);
        $display("idle cancel test done");
        // Reset in mid run with a mailbox waiting
        wr(`CMBX_OFF_PEND_LO, 32'h2);
        @(posedge clock);
        resetn <= 1'b0;
        repeat (3) @(posedge clock);
        chk("offer in reset", {31'h0, tx_req}, 32'h0);
        chk("irq in reset", {31'h0, irq}, 32'h0);
        resetn <= 1'b1;
        rchk("wait after reset", `CMBX_OFF_PEND_LO, 32'h0);
        rchk("dir after reset", `CMBX_OFF_DIR, 32'h0);
        $display("mid run reset test done");
        give_verdict();
    end
endmodule : tb_can_mailbox_tx_request_cancel
`default_nettype wire
